// file: pkg/pmc_pkg.sv
// Purpose: constants and types for the processor mode controller
// Assumes: APB slave, 32-bit data, one aligned word per register
// Notes: offsets are local choices; mode field sits in bits 1:0 of reg a
// What this block does
// R1: reset mode follows boot pin level
// R2: field 00 single, 01 expansion, 11 microprocessor
// R3: writing field sets mode regardless of pin
// R4: upper bits change blocks entering bus modes
// R5: software avoids unsafe switches around internal ROM
// R6: boot pin high at reset blocks ROM
// R7: mode registers writable only when unlocked
// R8: bus bits act only in bus modes
// R9: mode field survives soft resets
// R10: full multiplex needs byte pin high
// R11: software avoids full multiplex after high boot
// R12: rom block enable maps area, forced by flash
// R13: sticky bit sets on one only
// R14: global wait inserts RAM wait state
// R15: extended area forced by flash rewrite
// R16: extended bit selects memory limits
// R17: single-chip mode uses no bus pins
// R18: bus modes drive bus control pins
// R19: bus mode field selects separate or multiplexed
// R20: hard reset low pin gives single-chip defaults
package pmc_pkg;
  localparam logic [11:0] PMC_OFS_REG_A = 12'h000;
  localparam logic [11:0] PMC_OFS_REG_B = 12'h004;
  localparam logic [11:0] PMC_OFS_PROTECT = 12'h008;
  localparam logic [11:0] PMC_OFS_STATUS = 12'h00c;
  localparam logic [7:0] PMC_RST_REG_A_SINGLE = 8'h00;
  localparam logic [7:0] PMC_RST_REG_A_MICRO = 8'h03;
  localparam logic [7:0] PMC_RST_REG_B = 8'h08;
  localparam logic [7:0] PMC_STICKY_MASK = 8'h04;
  localparam int PMC_UNLOCK_BIT = 1;
  localparam int PMC_ROMBLK_BIT = 0;
  localparam int PMC_STICKY_BIT = 2;
  localparam int PMC_EXT_BIT = 3;
  localparam int PMC_WAIT_BIT = 7;
  localparam logic [19:0] PMC_RAM_LIM_LO = 20'h00400;
  localparam logic [19:0] PMC_RAM_LIM_HI = 20'h03fff;
  localparam logic [19:0] PMC_ROM_LIM_LO = 20'hd0000;
  localparam logic [19:0] PMC_EXT_A_LO = 20'h04000;
  localparam logic [19:0] PMC_EXT_A_HI = 20'h07fff;
  localparam logic [19:0] PMC_EXT_B_LO = 20'h80000;
  localparam logic [19:0] PMC_EXT_B_HI = 20'hcffff;
  localparam logic [19:0] PMC_BLKA_LO = 20'h0f000;
  localparam logic [19:0] PMC_BLKA_HI = 20'h0ffff;
  localparam logic [1:0] PMC_BUS_FULL_MUX = 2'h3;
  localparam logic [1:0] PMC_BUS_SEPARATE = 2'h0;
  localparam logic [1:0] PMC_SYNC_EDGES = 2'h2;

  typedef enum logic [1:0] {
    PMC_SINGLE = 2'h0,
    PMC_EXPAND = 2'h1,
    PMC_RSVD = 2'h2,
    PMC_MICRO = 2'h3
  } pmc_mode_t;

  typedef struct packed {
    logic bus_pins_en;
    logic full_mux;
    logic [1:0] bus_mode;
    logic [5:0] upper_bits;
    logic ext_area;
    logic global_wait;
  } pmc_bus_cfg_t;

  typedef struct packed {
    logic rom_enable;
    logic ram_wait;
    logic addr_ext;
  } pmc_mem_cfg_t;
endpackage

// file: hdl/pmc_mode_ctrl.sv
// Purpose: processor mode selection, mode register protection, memory gating
// Assumes: presetn is the hardware reset; soft resets arrive as pulses
// Notes: external bus cycles are run by the bus unit using bus_cfg
//
// Added by the designer: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
module pmc_mode_ctrl
  import pmc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic boot_mode_pin,
  input wire logic byte_pin,
  input wire logic flash_self_rewrite_mode,
  input wire logic soft_reset,
  input wire logic [19:0] cpu_addr,
  output pmc_mode_t mode,
  output pmc_bus_cfg_t bus_cfg,
  output pmc_mem_cfg_t mem_cfg,
  output logic rom_hit,
  output logic ram_hit,
  output logic ext_hit
);
  logic boot_s1_q, boot_s2_q, byte_s1_q, byte_s2_q, flash_s1_q, flash_s2_q;
  logic [7:0] reg_a_q, reg_b_q;
  logic unlock_q, rom_block_q, boot_latched_q, cfg_done_q;
  logic [1:0] cfg_cnt_q;
  logic cfg_take;
  logic wr_en, ofs_ok;
  logic [7:0] wdat;
  logic [1:0] new_mode;
  logic [19:0] a;

  function automatic logic ofs_valid(input logic [11:0] o);
    return (o == PMC_OFS_REG_A) || (o == PMC_OFS_REG_B) || (o == PMC_OFS_PROTECT) || (o == PMC_OFS_STATUS);
  endfunction

  function automatic logic in_range(input logic [19:0] x, input logic [19:0] lo, input logic [19:0] hi);
    return (x >= lo) && (x <= hi);
  endfunction

  // pins are asynchronous to pclk
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      boot_s1_q <= 1'b0;
      boot_s2_q <= 1'b0;
      byte_s1_q <= 1'b0;
      byte_s2_q <= 1'b0;
      flash_s1_q <= 1'b0;
      flash_s2_q <= 1'b0;
    end else begin
      boot_s1_q <= boot_mode_pin;
      boot_s2_q <= boot_s1_q;
      byte_s1_q <= byte_pin;
      byte_s2_q <= byte_s1_q;
      flash_s1_q <= flash_self_rewrite_mode;
      flash_s2_q <= flash_s1_q;
    end
  end

  assign pready = 1'b1;
  assign ofs_ok = ofs_valid(paddr);
  assign pslverr = psel && penable && !ofs_ok;
  assign wr_en = psel && penable && pwrite && ofs_ok;
  assign wdat = pwdata[7:0];
  assign new_mode = wdat[1:0];

  // the synchroniser's reset value must not pass for the pin level,
  // so the boot level is caught only once both stages hold the real pin
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_cnt_q <= '0;
    end else if (cfg_cnt_q != PMC_SYNC_EDGES) begin
      cfg_cnt_q <= cfg_cnt_q + 2'h1;
    end
  end

  assign cfg_take = (cfg_cnt_q == PMC_SYNC_EDGES) && !cfg_done_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_done_q <= 1'b0;
      boot_latched_q <= 1'b0;
    end else if (cfg_take) begin
      cfg_done_q <= 1'b1;
      boot_latched_q <= boot_s2_q;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      unlock_q <= 1'b0;
    end else if (soft_reset) begin
      unlock_q <= 1'b0;
    end else if (wr_en && paddr == PMC_OFS_PROTECT) begin
      unlock_q <= wdat[PMC_UNLOCK_BIT];
    end
  end

  // mode register a; field untouched by soft resets
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reg_a_q <= PMC_RST_REG_A_SINGLE; // see R20
    end else if (cfg_take) begin
      reg_a_q <= boot_s2_q ? PMC_RST_REG_A_MICRO : PMC_RST_REG_A_SINGLE; // see R1
    end else if (soft_reset) begin
      reg_a_q <= {PMC_RST_REG_A_SINGLE[7:2], reg_a_q[1:0]}; // see R9
    end else if (wr_en && paddr == PMC_OFS_REG_A && unlock_q) begin // see R7
      reg_a_q[7:2] <= wdat[7:2];
      // reserved code ignored; bus modes refused when upper bits change
      if (new_mode != PMC_RSVD
          && !(new_mode != PMC_SINGLE && wdat[7:2] != reg_a_q[7:2])) begin // see R4
        reg_a_q[1:0] <= new_mode; // see R3
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reg_b_q <= PMC_RST_REG_B; // see R20
    end else if (soft_reset) begin
      reg_b_q <= PMC_RST_REG_B;
    end else if (wr_en && paddr == PMC_OFS_REG_B && unlock_q) begin // see R7
      reg_b_q <= (wdat & ~PMC_STICKY_MASK) | ((wdat | reg_b_q) & PMC_STICKY_MASK); // see R13
    end
  end

  // blocks internal ROM until the next hardware reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rom_block_q <= 1'b0;
    end else if (cfg_take) begin
      rom_block_q <= boot_s2_q; // see R6
    end
  end

  assign mode = pmc_mode_t'(reg_a_q[1:0]); // see R2

  logic bus_mode_on, ext_eff, romblk_eff;
  assign bus_mode_on = (mode == PMC_EXPAND) || (mode == PMC_MICRO); // see R17
  assign ext_eff = reg_b_q[PMC_EXT_BIT] | flash_s2_q; // see R15
  assign romblk_eff = reg_b_q[PMC_ROMBLK_BIT] | flash_s2_q; // see R12

  always_comb begin
    bus_cfg = '0;
    if (bus_mode_on) begin // see R8
      bus_cfg.bus_pins_en = 1'b1; // see R18
      bus_cfg.bus_mode = reg_a_q[5:4]; // see R19
      bus_cfg.upper_bits = reg_a_q[7:2];
      // full multiplex only with 8-bit bus in expansion mode
      bus_cfg.full_mux = (reg_a_q[5:4] == PMC_BUS_FULL_MUX) && (mode == PMC_EXPAND) && byte_s2_q; // see R10
      bus_cfg.ext_area = ext_eff;
      bus_cfg.global_wait = reg_b_q[PMC_WAIT_BIT];
    end
  end

  assign mem_cfg.rom_enable = !rom_block_q && (mode != PMC_MICRO);
  assign mem_cfg.ram_wait = reg_b_q[PMC_WAIT_BIT]; // see R14
  assign mem_cfg.addr_ext = ext_eff;

  // address decode of the memory map
  assign a = cpu_addr;
  always_comb begin
    ram_hit = ext_eff ? (a >= PMC_RAM_LIM_LO && a < PMC_EXT_A_LO) || in_range(a, PMC_EXT_A_LO, PMC_EXT_A_HI)
                      : in_range(a, PMC_RAM_LIM_LO, PMC_RAM_LIM_HI); // see R16
    rom_hit = mem_cfg.rom_enable
              && ((ext_eff ? in_range(a, PMC_EXT_B_LO, PMC_EXT_B_HI) : 1'b0) || a >= PMC_ROM_LIM_LO
                  || (romblk_eff && in_range(a, PMC_BLKA_LO, PMC_BLKA_HI))); // see R12
    // the register area below internal RAM is never external
    ext_hit = bus_mode_on && (a >= PMC_RAM_LIM_LO) && !ram_hit && !rom_hit
              && !(ext_eff && in_range(a, PMC_EXT_B_LO, PMC_EXT_B_HI)); // see R18
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
    end else if (psel && !penable && !pwrite) begin
      unique case (paddr)
        PMC_OFS_REG_A: prdata <= {24'h000000, reg_a_q};
        PMC_OFS_REG_B: prdata <= {24'h000000, reg_b_q[7:4], ext_eff, reg_b_q[2:1], romblk_eff};
        PMC_OFS_PROTECT: prdata <= {30'h0, unlock_q, 1'b0};
        PMC_OFS_STATUS: prdata <= {28'h0000000, bus_cfg.full_mux, rom_block_q, boot_latched_q, byte_s2_q};
        default: prdata <= '0;
      endcase
    end
  end
endmodule // pmc_mode_ctrl

// file: tb/pmc_mode_ctrl_monitor.sv
// Purpose: port-level checks for the mode controller
// Assumes: bound to pmc_mode_ctrl, one clock domain
// Notes: a soft reset that meets a write is not judged
`timescale 1ns/1ps
module pmc_mode_ctrl_monitor
  import pmc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic penable,
  input wire logic soft_reset,
  input wire logic flash_self_rewrite_mode,
  input wire logic [19:0] cpu_addr,
  input wire logic ram_hit,
  input wire pmc_mode_t mode,
  input wire pmc_bus_cfg_t bus_cfg,
  input wire pmc_mem_cfg_t mem_cfg
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_single_no_bus: assert property (mode == PMC_SINGLE |-> bus_cfg == '0)
    else $error("bus config active in single-chip mode");
  a_bus_pins_on: assert property (mode inside {PMC_EXPAND, PMC_MICRO} |-> bus_cfg.bus_pins_en)
    else $error("bus pins off in a bus mode");
  a_mode_not_rsvd: assert property (mode != PMC_RSVD)
    else $error("reserved mode reached");
  a_soft_keeps_mode: assert property (soft_reset && !penable |=> $stable(mode))
    else $error("soft reset changed mode");
  a_flash_forces_ext: assert property (flash_self_rewrite_mode [*4] |-> mem_cfg.addr_ext)
    else $error("extended area not forced");
  a_ram_limit: assert property (!mem_cfg.addr_ext && cpu_addr inside {[PMC_EXT_A_LO:PMC_EXT_A_HI]} |-> !ram_hit)
    else $error("ram hit outside limited range");
  a_mux_code: assert property (bus_cfg.full_mux |-> bus_cfg.bus_mode == PMC_BUS_FULL_MUX)
    else $error("full multiplex without its code");
  a_bus_bits_gate: assert property (bus_cfg.bus_mode != 2'h0 |-> mode != PMC_SINGLE)
    else $error("bus mode bits act in single-chip");
  a_micro_no_rom: assert property (mode == PMC_MICRO |-> !mem_cfg.rom_enable)
    else $error("internal ROM enabled in microprocessor mode");
endmodule // pmc_mode_ctrl_monitor

// file: tb/pmc_board_model.sv
// Purpose: board straps facing the mode controller
// Assumes: straps settle before reset release
// Notes: byte pin kept high so full multiplex stays legal
`timescale 1ns/1ps
module pmc_board_model (
  input wire logic boot_sel,
  output logic boot_mode_pin,
  output logic byte_pin
);
  assign boot_mode_pin = boot_sel;
  assign byte_pin = 1'b1;
endmodule // pmc_board_model

// file: tb/tb_pmc_mode_ctrl.sv
// Purpose: self-checking bench for the mode controller
// Assumes: zero-wait APB slave, low 8 data bits used
// Notes: random writes stay with boot pin low, where full multiplex is legal
`timescale 1ns/1ps
module tb_pmc_mode_ctrl;
  import pmc_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, boot_sel, boot_mode_pin, byte_pin, flash, soft_reset;
  logic ram_hit, rom_hit, ext_hit, er;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, seed;
  logic [19:0] cpu_addr;
  logic [7:0] ra, w;
  pmc_mode_t mode;
  pmc_bus_cfg_t bus_cfg;
  pmc_mem_cfg_t mem_cfg;
  int error_cnt, cmp_count, i;
  pmc_mode_ctrl i_pmc_mode_ctrl (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .boot_mode_pin(boot_mode_pin),
    .byte_pin(byte_pin), .flash_self_rewrite_mode(flash), .soft_reset(soft_reset), .cpu_addr(cpu_addr), .mode(mode),
    .bus_cfg(bus_cfg), .mem_cfg(mem_cfg), .rom_hit(rom_hit), .ram_hit(ram_hit), .ext_hit(ext_hit));
  pmc_board_model i_pmc_board_model (.boot_sel(boot_sel), .boot_mode_pin(boot_mode_pin), .byte_pin(byte_pin));
  always #25 pclk = ~pclk;
  function logic [31:0] lfsr(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function logic [1:0] nxt(logic [7:0] o, logic [7:0] v);
    if (v[1:0] == 2'h2 || (v[1:0] != 2'h0 && v[7:2] != o[7:2])) return o[1:0];
    return v[1:0];
  endfunction
  // extended area on, ROM block off: RAM 00400h-07fffh, ROM from 80000h, registers below RAM
  function logic [2:0] hit_exp(logic [1:0] md, logic [19:0] a);
    logic ram, rom, ext;
    ram = (a >= 20'h00400) && (a <= 20'h07fff);
    rom = (md != 2'h3) && (a >= 20'h80000);
    ext = (md != 2'h0) && (a >= 20'h08000) && ((a < 20'h80000) || (md == 2'h3 && a >= 20'hd0000));
    return {rom, ram, ext};
  endfunction
  task chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      error_cnt++;
      $display("ERROR t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task apb(input logic wr_en, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr_en;
    paddr <= a;
    pwdata <= d;
    penable <= 1'b0;
    @(posedge pclk) penable <= 1'b1;
    // no wait count is assumed; only the watchdog ends a stuck transfer
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d); apb(1'b1, a, d); endtask
  task rd_chk(input logic [11:0] a, input logic [31:0] e); apb(1'b0, a, 32'h0); chk(rd, e); endtask
  task rst(input logic b);
    presetn <= 1'b0; boot_sel <= b;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    repeat (5) @(posedge pclk);
  endtask
  task end_of_test;
    $display("errors %0d compares %0d", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    #200000;
    error_cnt++;
    end_of_test;
  end
  initial begin
    pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0; boot_sel = 0; flash = 0;
    soft_reset = 0; cpu_addr = 0; seed = 32'h0001821d; ra = PMC_RST_REG_A_SINGLE; error_cnt = 0; cmp_count = 0;
    rst(1'b0);
    chk(32'(mode), 32'(PMC_SINGLE));
    rd_chk(PMC_OFS_REG_A, 32'(PMC_RST_REG_A_SINGLE));
    rd_chk(PMC_OFS_REG_B, 32'(PMC_RST_REG_B));
    wr(PMC_OFS_REG_A, 32'h01);
    chk(32'(mode), 32'(PMC_SINGLE));
    wr(PMC_OFS_PROTECT, 32'h02);
    for (i = 0; i < 24; i++) begin
      seed = lfsr(seed);
      w = (i < 4) ? {ra[7:2], i[1:0]} : (i == 4) ? {~ra[7:2], 2'h3} : seed[7:0];
      cpu_addr <= seed[31:12];
      wr(PMC_OFS_REG_A, 32'(w));
      ra = {w[7:2], nxt(ra, w)};
      rd_chk(PMC_OFS_REG_A, 32'(ra));
      chk(32'(mode), 32'(ra[1:0]));
      chk(32'({rom_hit, ram_hit, ext_hit}), 32'(hit_exp(ra[1:0], cpu_addr)));
    end
    wr(PMC_OFS_REG_B, 32'h0c);
    wr(PMC_OFS_REG_B, 32'h88);
    rd_chk(PMC_OFS_REG_B, 32'h8c);
    chk(32'(mem_cfg.ram_wait), 32'h1);
    wr(PMC_OFS_REG_B, 32'h84);
    cpu_addr <= 20'h05000;
    @(posedge pclk);
    chk(32'(ram_hit), 32'h0);
    flash <= 1'b1;
    repeat (4) @(posedge pclk);
    rd_chk(PMC_OFS_REG_B, 32'h8d);
    flash <= 1'b0;
    wr(PMC_OFS_REG_A, {24'h0, ra[7:2], 2'h1});
    chk(32'(mode), 32'(PMC_EXPAND));
    soft_reset <= 1'b1;
    @(posedge pclk) soft_reset <= 1'b0;
    @(posedge pclk);
    chk(32'(mode), 32'(PMC_EXPAND));
    rd_chk(PMC_OFS_REG_A, 32'h01);
    rd_chk(PMC_OFS_REG_B, 32'(PMC_RST_REG_B));
    wr(PMC_OFS_REG_A, 32'h00);
    chk(32'(mode), 32'(PMC_EXPAND));
    apb(1'b0, 12'h010, 32'h0);
    chk(32'(er), 32'h1);
    chk(rd, 32'h0);
    rst(1'b1);
    chk(32'(mode), 32'(PMC_MICRO));
    rd_chk(PMC_OFS_STATUS, 32'h7);
    wr(PMC_OFS_PROTECT, 32'h02);
    wr(PMC_OFS_REG_A, 32'h00);
    chk(32'(mode), 32'(PMC_SINGLE));
    chk(32'(mem_cfg.rom_enable), 32'h0);
    end_of_test;
  end
endmodule // tb_pmc_mode_ctrl
bind pmc_mode_ctrl pmc_mode_ctrl_monitor i_pmc_mode_ctrl_monitor (.pclk(pclk), .presetn(presetn), .penable(penable),
  .soft_reset(soft_reset), .flash_self_rewrite_mode(flash_self_rewrite_mode), .cpu_addr(cpu_addr), .ram_hit(ram_hit),
  .mode(mode), .bus_cfg(bus_cfg), .mem_cfg(mem_cfg));
